/* sim/ptsp_chk_sva.sv */
// Port-three block checker
`timescale 1ns/1ps
`default_nettype none
module ptsp_chk (
	input wire logic       mclk,                    // Clock
	input wire logic       nrst,                    // Reset
	input wire logic [7:0] bus_wdata,               // Data
	input wire logic       latch_wr,                // Load
	input wire logic       bit_wr,                  // Bit load
	input wire logic [2:0] bit_sel,                 // Bit
	input wire logic       bit_val,                 // Value
	input wire logic       latch_rd,                // Read
	input wire logic [7:0] bus_rdata,               // Result
	input wire logic [7:0] port_three_latch,        // Latch
	input wire logic [7:0] pin_oe_n,                // Drive
	input wire logic       pwm1_sel,                // Select
	input wire logic       pwm1,                    // Pwm
	input wire logic       serial_interface_select, // Mode
	input wire logic       sclk_oe_n,               // Drive
	input wire logic       sclk_strong_pu,          // Pull
	input wire logic       serial_clock_pin,        // Pin
	input wire logic       i2c_sclk_in              // Filtered
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	property p_ld; latch_wr |=> port_three_latch == $past(bus_wdata); endproperty
	a_ld: assert property (p_ld) else $error("latch load");
	property p_bit; bit_wr && !latch_wr |=> port_three_latch[$past(bit_sel)] == $past(bit_val) &&
		((port_three_latch ^ $past(port_three_latch)) & ~(8'h01 << $past(bit_sel))) == 8'h00; endproperty
	a_bit: assert property (p_bit) else $error("bit write");
	property p_rd; latch_rd |=> bus_rdata == $past(port_three_latch); endproperty
	a_rd: assert property (p_rd) else $error("latch read");
	property p_low; !port_three_latch[2] |-> !pin_oe_n[2]; endproperty
	a_low: assert property (p_low) else $error("low drive");
	property p_pu; port_three_latch[5] |-> pin_oe_n[5]; endproperty
	a_pu: assert property (p_pu) else $error("pull-up");
	property p_pwm; pwm1_sel |-> pin_oe_n[3] == pwm1; endproperty
	a_pwm: assert property (p_pwm) else $error("pwm");
	property p_pp; serial_interface_select |-> !sclk_oe_n; endproperty
	a_pp: assert property (p_pp) else $error("push-pull");
	property p_weak; !serial_interface_select |-> !sclk_strong_pu; endproperty
	a_weak: assert property (p_weak) else $error("strong pull");
	property p_flt; $changed(i2c_sclk_in) |-> $past(serial_clock_pin, 3) == i2c_sclk_in &&
		$past(serial_clock_pin, 6) == i2c_sclk_in; endproperty
	a_flt: assert property (p_flt) else $error("glitch");
	c_bit: cover property (bit_wr);
	c_pwm: cover property (pwm1_sel);
	c_flt: cover property ($fell(i2c_sclk_in));
endmodule : ptsp_chk
bind ptsp_port ptsp_chk chk_i (.*);
`default_nettype wire

/* sim/ptsp_ext.sv */
// Devices on the port and clock pins
`timescale 1ns/1ps
`default_nettype none
module ptsp_ext (
	input wire logic [7:0] pin_oe_n,           // Drive
	input wire logic [7:0] pin_pullup,         // Pull
	input wire logic [7:0] ext_low,            // Loads
	output logic     [7:0] pin_in,             // Pins
	input wire logic       sclk_oe_n,          // Drive
	input wire logic       sclk_out,           // Value
	input wire logic       serial_pin_weak_pu, // Pull
	input wire logic       ext_sclk_low,       // Load
	output logic           serial_clock_pin    // Pin
);
	// Weak pull-up loses to any load
	assign pin_in = pin_oe_n & pin_pullup & ~ext_low;
	assign serial_clock_pin = (sclk_oe_n ? serial_pin_weak_pu : sclk_out) & ~ext_sclk_low;
endmodule : ptsp_ext
`default_nettype wire

/* sim/ptsp_port_tb.sv */
// Bench for the port-three block
`timescale 1ns/1ps
`default_nettype none
module ptsp_port_tb;
	logic mclk, nrst, latch_wr, bit_wr, bit_val, latch_rd, pin_rd, uart_txd, uart_rxd_out, xmem_wr_n, xmem_rd_n;
	logic pwm0_sel, pwm1_sel, pwm0, pwm1, serial_interface_select, i2c_master, sw_sclk, sw_sdata, spi_sclk_out;
	logic spi_mosi_out, i2c_sclk_low, i2c_sdata_low, serial_clock_pin, serial_data_pin, ext_sclk_low, uart_rxd;
	logic ext_irq_zero_pin, ext_irq_one_pin, spi_miso, timer_zero_count_input, pwm_ext_clk, timer_one_count_input;
	logic sclk_out, sclk_oe_n, sclk_strong_pu, sdata_out, sdata_oe_n, sdata_strong_pu, serial_pin_weak_pu;
	logic i2c_sclk_in, i2c_sdata_in, spi_sclk_in, spi_mosi_in;
	logic [7:0] bus_wdata, bus_rdata, port_three_latch, pin_in, pin_out, pin_oe_n, pin_pullup, ext_low, e, r;
	logic [2:0] bit_sel;
	logic [31:0] lfsr = 32'ha32d;
	int fails = 0, n_checks = 0, i, k;
	ptsp_port dut (.*);
	ptsp_ext far (.*);
	assign serial_data_pin = sdata_oe_n | sdata_out;
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction : rnd
	function automatic logic [7:0] exp_oe(input logic [7:0] l);
		exp_oe = l & {xmem_rd_n, xmem_wr_n, 4'hf, uart_txd, uart_rxd_out};
		if (pwm1_sel) exp_oe[3] = pwm1;
		if (pwm0_sel) exp_oe[4] = pwm0;
	endfunction : exp_oe
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n = 1);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic report_and_stop();
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	initial begin
		{nrst, latch_wr, bit_wr, bit_val, latch_rd, pin_rd, pwm0_sel, pwm1_sel, pwm0, pwm1, ext_sclk_low} = '0;
		{uart_txd, uart_rxd_out, xmem_wr_n, xmem_rd_n, i2c_master, sw_sclk, sw_sdata} = '1;
		{serial_interface_select, spi_sclk_out, spi_mosi_out, i2c_sclk_low, i2c_sdata_low} = '0;
		{bus_wdata, bit_sel, ext_low} = '0;
		tick(2);
		nrst = 1;
		chk(port_three_latch, 8'hff);
		chk(pin_oe_n, 8'hff);
		chk(pin_pullup, 8'hff);
		chk(pin_out, 8'h00);
		$display("reset test done");
		for (i = 0; i < 200; i++) begin
			e = rnd();
			{uart_txd, uart_rxd_out, xmem_wr_n, xmem_rd_n, pwm0_sel, pwm1_sel, pwm0, pwm1} = rnd();
			bus_wdata = e;
			latch_wr = 1;
			tick();
			latch_wr = 0;
			chk(port_three_latch, e);
			chk(pin_oe_n, exp_oe(e));
			ext_low = rnd();
			r = rnd();
			// Pins pass two sync stages before a pin read can see them
			tick(2);
			{latch_rd, pin_rd, bit_val, bit_sel} = {r[0], 1'b1, r[1], r[4:2]};
			tick();
			{latch_rd, pin_rd, bit_wr} = 3'h1;
			chk(bus_rdata, r[0] ? e : exp_oe(e) & ~ext_low);
			e[bit_sel] = bit_val;
			tick();
			bit_wr = 0;
			chk(port_three_latch, e);
		end
		$display("random test done");
		{pwm0_sel, pwm1_sel, bus_wdata, latch_wr, ext_low} = {10'h0ff, 1'b1, 8'h3f};
		{uart_txd, uart_rxd_out, xmem_wr_n, xmem_rd_n} = 4'hf;
		tick();
		latch_wr = 0;
		tick(3);
		chk({uart_rxd, ext_irq_zero_pin, ext_irq_one_pin, spi_miso, timer_zero_count_input,
			pwm_ext_clk, timer_one_count_input}, 8'h00);
		ext_low = 0;
		tick(3);
		chk({uart_rxd, ext_irq_zero_pin, ext_irq_one_pin, spi_miso, timer_zero_count_input,
			pwm_ext_clk, timer_one_count_input}, 8'h7f);
		{serial_interface_select, spi_sclk_out} = 2'h3;
		tick();
		chk({sclk_oe_n, sclk_strong_pu}, 8'h01);
		{serial_interface_select, sw_sdata} = 2'h0;
		tick();
		chk({sclk_strong_pu, sdata_strong_pu, sdata_oe_n}, 8'h00);
		sw_sdata = 1;
		ext_sclk_low = 1;
		tick(5);
		ext_sclk_low = 0;
		for (k = 0; k < 15; k++) begin
			tick();
			chk(i2c_sclk_in, 8'h01);
		end
		ext_sclk_low = 1;
		for (k = 0; k < 20 && i2c_sclk_in !== 1'b0; k++) tick();
		chk(k < 20, 8'h01);
		chk(8'(k), 8'(ptsp_pkg::FILT_CYC + 2));
		chk({i2c_sdata_in, spi_mosi_in, spi_sclk_in, serial_pin_weak_pu}, 8'h0d);
		$display("serial test done");
		report_and_stop();
	end
endmodule : ptsp_port_tb
`default_nettype wire

/* verilog/ptsp_pkg.sv */
// Constants for the port-three and serial pin block
package ptsp_pkg;
	localparam int         WIDTH        = 8;
	localparam logic [7:0] LATCH_RST    = 8'hFF;
	localparam int         BIT_RXD      = 0;
	localparam int         BIT_TXD      = 1;
	localparam int         BIT_IRQ0     = 2;
	localparam int         BIT_IRQ1     = 3;
	localparam int         BIT_T0       = 4;
	localparam int         BIT_T1       = 5;
	localparam int         BIT_WR       = 6;
	localparam int         BIT_RD       = 7;
	localparam int         GLITCH_NS    = 50;
	localparam int         CLK_NS       = 10;
	// Glitch up to this long is rejected: need one more stable cycle than it spans
	localparam int         FILT_CYC     = (GLITCH_NS + CLK_NS - 1) / CLK_NS + 1;
	localparam logic [3:0] FILT_MAX     = 4'(FILT_CYC);
	localparam logic [3:0] FILT_ZERO    = 4'h0;
endpackage : ptsp_pkg

/* verilog/ptsp_port.sv */
// Port three latch, pin drivers, read paths and serial pin conditioning
// Behaviour
// RL1: Latch one gives weak pull-up, input use
// RL2: Latch zero drives pin low
// RL3: Alternate function only while latch holds one; code lets selected pwm drive bits 3, 4 whatever the latch holds
// RL4: Bit0 receive data, bit1 transmit/serial clock
// RL5: Bit2 irq0, bit3 irq1/pwm1/miso, bit4 t0/pwm0
// RL6: Bit5 t1, bit6 write strobe, bit7 read
// RL7: Selected pwm outputs override bits 3, 4
// RL8: I2C mode: no strong pull-up, weak only
// RL9: SPI mode: SPI controls strong pull-up
// RL10: Filter serial inputs, reject 50 ns glitches; code filters only the I2C inputs, SPI inputs are only synchronised
// RL11: I2C master: software drives serial pins directly
// RL12: Master-in data shares bit3 port buffer
// RL13: Plain reads pins; read-modify-write reads latch
// RL14: Bit operations rewrite whole latch byte
// RL15: Read-modify-write operand taken from latch
// RL16: Latch loads on write, presents on read strobes
// RL17: Latch resets to all ones
`timescale 1ns/1ps
`default_nettype none
module ptsp_port (
	input  wire logic       mclk,            // Core clock
	input  wire logic       nrst,            // Sync reset, active low
	input  wire logic [7:0] bus_wdata,       // Internal bus write data
	input  wire logic       latch_wr,        // Write byte to latch
	input  wire logic       bit_wr,          // Write single bit (read-modify-write)
	input  wire logic [2:0] bit_sel,         // Addressed bit
	input  wire logic       bit_val,         // New value of addressed bit
	input  wire logic       latch_rd,        // Read latch strobe
	input  wire logic       pin_rd,          // Read pin strobe
	output logic      [7:0] bus_rdata,       // Read data to internal bus
	output logic      [7:0] port_three_latch, // Latch contents
	input  wire logic [7:0] pin_in,          // Port pin levels
	output logic      [7:0] pin_out,         // Port pin drive value
	output logic      [7:0] pin_oe_n,        // Low while pin driven low
	output logic      [7:0] pin_pullup,      // Weak pull-up enable
	input  wire logic       uart_txd,        // Transmit data / mode 0 clock
	input  wire logic       uart_rxd_out,    // Mode 0 serial data out
	input  wire logic       xmem_wr_n,       // External write strobe
	input  wire logic       xmem_rd_n,       // External read strobe
	input  wire logic       pwm0_sel,        // Pwm 0 onto bit 4
	input  wire logic       pwm1_sel,        // Pwm 1 onto bit 3
	input  wire logic       pwm0,            // Pwm 0 output level
	input  wire logic       pwm1,            // Pwm 1 output level
	output logic            uart_rxd,        // Receive data to UART
	output logic            ext_irq_zero_pin, // Irq 0 input
	output logic            ext_irq_one_pin, // Irq 1 input
	output logic            spi_miso,        // Master-in data
	output logic            timer_zero_count_input, // Timer 0 count input
	output logic            pwm_ext_clk,     // Pwm external clock
	output logic            timer_one_count_input, // Timer 1 count input
	input  wire logic       serial_interface_select, // 1 SPI, 0 I2C
	input  wire logic       i2c_master,      // I2C master mode
	input  wire logic       sw_sclk,         // Software serial clock level
	input  wire logic       sw_sdata,        // Software serial data level
	input  wire logic       spi_sclk_out,    // SPI clock output
	input  wire logic       spi_mosi_out,    // SPI data output
	input  wire logic       i2c_sclk_low,    // I2C logic pulls clock low
	input  wire logic       i2c_sdata_low,   // I2C logic pulls data low
	input  wire logic       serial_clock_pin, // Clock pin level
	input  wire logic       serial_data_pin, // Data pin level
	output logic            sclk_out,        // Clock pin drive value
	output logic            sclk_oe_n,       // Clock pin enable, low drives
	output logic            sclk_strong_pu,  // Clock strong pull-up
	output logic            sdata_out,       // Data pin drive value
	output logic            sdata_oe_n,      // Data pin enable, low drives
	output logic            sdata_strong_pu, // Data strong pull-up
	output logic            serial_pin_weak_pu, // Weak pull-ups on serial pins
	output logic            i2c_sclk_in,     // Filtered clock to I2C
	output logic            i2c_sdata_in,    // Filtered data to I2C
	output logic            spi_sclk_in,     // Clock to SPI
	output logic            spi_mosi_in      // Data to SPI
);
	logic [7:0] latch_q;
	logic [7:0] pin_s1_q, pin_s2_q;
	logic [7:0] alt_out;
	logic [7:0] drive;
	logic [1:0] ser_s1_q, ser_s2_q;
	logic [1:0] filt_q;
	logic [3:0] cnt_q [2];
	logic [7:0] rd_q;

	// Latch: byte write or bit write of whole byte
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			latch_q <= ptsp_pkg::LATCH_RST; // RL17
		end else if (latch_wr) begin
			latch_q <= bus_wdata; // RL16
		end else if (bit_wr) begin
			latch_q <= latch_q; // RL14
			latch_q[bit_sel] <= bit_val; // RL14
		end
	end
	assign port_three_latch = latch_q;

	// Pins are asynchronous: two-stage synchroniser
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pin_s1_q <= ptsp_pkg::LATCH_RST;
			pin_s2_q <= ptsp_pkg::LATCH_RST;
		end else begin
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Read data registered; latch read takes priority so RMW sees latch
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rd_q <= ptsp_pkg::LATCH_RST;
		end else if (latch_rd) begin
			rd_q <= latch_q; // RL13 RL15
		end else if (pin_rd) begin
			rd_q <= pin_s2_q; // RL13
		end
	end
	assign bus_rdata = rd_q;

	// Alternate output values; input-only functions idle high
	always_comb begin
		alt_out = ptsp_pkg::LATCH_RST;
		alt_out[ptsp_pkg::BIT_RXD] = uart_rxd_out; // RL4
		alt_out[ptsp_pkg::BIT_TXD] = uart_txd; // RL4
		alt_out[ptsp_pkg::BIT_WR]  = xmem_wr_n; // RL6
		alt_out[ptsp_pkg::BIT_RD]  = xmem_rd_n; // RL6
	end

	// Per-bit drive: latch AND alternate, with pwm overriding latch
	genvar g;
	generate
		for (g = 0; g < ptsp_pkg::WIDTH; g++) begin : g_bit
			always_comb begin
				if (g == ptsp_pkg::BIT_IRQ1 && pwm1_sel) begin
					drive[g] = pwm1; // RL7
				end else if (g == ptsp_pkg::BIT_T0 && pwm0_sel) begin
					drive[g] = pwm0; // RL7
				end else begin
					drive[g] = latch_q[g] & alt_out[g]; // RL1 RL2 RL3
				end
			end
			// Quasi-bidirectional: only a low is driven, high comes from pull-up
			assign pin_out[g]    = 1'b0;
			assign pin_oe_n[g]   = drive[g]; // RL2
			assign pin_pullup[g] = 1'b1; // RL1
		end
	endgenerate

	// Alternate inputs read the synchronised pins
	assign uart_rxd               = pin_s2_q[ptsp_pkg::BIT_RXD]; // RL4
	assign ext_irq_zero_pin       = pin_s2_q[ptsp_pkg::BIT_IRQ0]; // RL5
	assign ext_irq_one_pin        = pin_s2_q[ptsp_pkg::BIT_IRQ1]; // RL5
	assign spi_miso               = pin_s2_q[ptsp_pkg::BIT_IRQ1]; // RL12
	assign timer_zero_count_input = pin_s2_q[ptsp_pkg::BIT_T0]; // RL5
	assign pwm_ext_clk            = pin_s2_q[ptsp_pkg::BIT_T0]; // RL5
	assign timer_one_count_input  = pin_s2_q[ptsp_pkg::BIT_T1]; // RL6

	// Serial pins: SPI push-pull, I2C open drain with weak pull-up
	logic sclk_val, sdata_val;
	always_comb begin
		if (serial_interface_select) begin
			sclk_val  = spi_sclk_out;
			sdata_val = spi_mosi_out;
		end else if (i2c_master) begin
			sclk_val  = sw_sclk & ~i2c_sclk_low; // RL11
			sdata_val = sw_sdata & ~i2c_sdata_low; // RL11
		end else begin
			sclk_val  = ~i2c_sclk_low;
			sdata_val = ~i2c_sdata_low;
		end
	end
	assign sclk_out           = sclk_val;
	assign sdata_out          = sdata_val;
	assign sclk_oe_n          = serial_interface_select ? 1'b0 : sclk_val; // RL9
	assign sdata_oe_n         = serial_interface_select ? 1'b0 : sdata_val; // RL9
	assign sclk_strong_pu     = serial_interface_select & spi_sclk_out; // RL8 RL9
	assign sdata_strong_pu    = serial_interface_select & spi_mosi_out; // RL8 RL9
	assign serial_pin_weak_pu = 1'b1; // RL8

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ser_s1_q <= 2'h3;
			ser_s2_q <= 2'h3;
		end else begin
			ser_s1_q <= {serial_data_pin, serial_clock_pin};
			ser_s2_q <= ser_s1_q;
		end
	end
	assign spi_sclk_in = ser_s2_q[0];
	assign spi_mosi_in = ser_s2_q[1];

	// Filter: output follows only after input stable FILT_CYC cycles
	generate
		for (g = 0; g < 2; g++) begin : g_filt
			always_ff @(posedge mclk) begin
				if (!nrst) begin
					filt_q[g]   <= 1'b1;
					cnt_q[g]    <= ptsp_pkg::FILT_ZERO;
				end else if (ser_s2_q[g] == filt_q[g]) begin
					cnt_q[g]    <= ptsp_pkg::FILT_ZERO; // RL10
				end else if (cnt_q[g] == ptsp_pkg::FILT_MAX - 4'h1) begin
					filt_q[g]   <= ser_s2_q[g]; // RL10
					cnt_q[g]    <= ptsp_pkg::FILT_ZERO;
				end else begin
					cnt_q[g]    <= cnt_q[g] + 4'h1; // RL10
				end
			end
		end
	endgenerate
	assign i2c_sclk_in  = filt_q[0];
	assign i2c_sdata_in = filt_q[1];
endmodule : ptsp_port
`default_nettype wire
